/* design/shf_pkg.sv */
package shf_pkg;

  // ********************************************************************
  // Sizes and counter width
  // ********************************************************************
  localparam int HDR_BITS    = 80;
  localparam int HDR_BYTES   = 10;
  localparam int ETYPE_BYTES = 2;
  localparam int INS_BYTES   = HDR_BYTES + ETYPE_BYTES;
  localparam int INS_BITS    = INS_BYTES * 8;
  localparam int CNT_W       = 4;

  // ********************************************************************
  // Header bit positions
  // ********************************************************************
  localparam int MARKER_POS = 79;
  localparam int COS_HI     = 78;
  localparam int COS_LO     = 76;
  localparam int INGRESS_SERVICE_INDEX_HI    = 75;
  localparam int INGRESS_SERVICE_INDEX_LO    = 64;
  localparam int RSVA_HI    = 78;
  localparam int RSVA_LO    = 68;
  localparam int AC_HI      = 67;
  localparam int AC_LO      = 64;
  localparam int RSVB_HI    = 63;
  localparam int RSVB_LO    = 62;
  localparam int DP_HI      = 61;
  localparam int DP_LO      = 60;
  localparam int SP_POS     = 59;
  localparam int PRIO_HI    = 58;
  localparam int PRIO_LO    = 56;
  localparam int CONG_POS   = 55;
  localparam int RSVC_POS   = 54;
  localparam int RSVD_POS   = 53;
  localparam int TTL_HI     = 52;
  localparam int TTL_LO     = 48;
  localparam int LRN_POS    = 47;
  localparam int FWD_HI     = 46;
  localparam int FWD_LO     = 44;
  localparam int RSVE_POS   = 43;
  localparam int DST_HI     = 42;
  localparam int DST_LO     = 32;
  localparam int LOW_HI     = 31;

  // ********************************************************************
  // Register map and reset values
  // ********************************************************************
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_BAD_COUNT = 8'h08;
  localparam logic [7:0]  REG_GOOD_COUNT = 8'h0c;
  localparam int          CTRL_LAYOUT_BIT = 0;
  localparam logic        CTRL_LAYOUT_RST = 1'b0;
  localparam int          ST_MARKER_BIT = 0;
  localparam int          ST_ETYPE_BIT  = 1;
  localparam int          ST_RSV_BIT    = 2;
  localparam int          ST_FWDRSV_BIT = 3;
  localparam int          ST_TXBUSY_BIT = 4;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    FWD_LOCAL_LOOKUP  = 3'h0,
    FWD_PORT_A        = 3'h1,
    FWD_PORT_B        = 3'h2,
    FWD_GROUP         = 3'h3,
    FWD_GLOBAL_MIRROR = 3'h4,
    FWD_ONE_UNIT_CPU  = 3'h5,
    FWD_ALL_CPUS      = 3'h6,
    FWD_RESERVED      = 3'h7
  } shf_fwd_e;

  typedef struct packed {
    logic [2:0]  class_of_service_id;
    logic [11:0] ingress_service_index;
    logic [3:0]  aggregation_code;
    logic [1:0]  drop_precedence;
    logic        super_priority_flag;
    logic [2:0]  internal_priority;
    logic        ingress_congestion_policy;
    logic [4:0]  ttl;
    logic        learning_skip;
    shf_fwd_e    forward_mode;
    logic [10:0] dst_field;
    logic [31:0] lower_bits;
  } shf_fields_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01
  } shf_state_e;

endpackage

/* design/shf_tx.sv */
`timescale 1ns/1ps

// Sends a prepared insertion (tag type plus header) one byte per accepted beat.
module shf_tx #(
  parameter int NBYTES = shf_pkg::INS_BYTES
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                start,
  input  wire logic [NBYTES*8-1:0] word,
  output logic                     idle,
  output logic                     out_valid,
  output logic [7:0]               out_data,
  output logic                     out_last,
  input  wire logic                out_ready
);

  initial begin
    if (NBYTES < 2 || NBYTES > 15) begin
      $error("shf_tx: NBYTES out of range");
    end
  end

  shf_pkg::shf_state_e           state_r, state_nxt;
  logic [NBYTES*8-1:0]           shift_r, shift_nxt;
  logic [shf_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
  logic                          valid_r, valid_nxt;
  logic                          last_r, last_nxt;

  localparam logic [shf_pkg::CNT_W-1:0] LAST_IDX = shf_pkg::CNT_W'(NBYTES - 1);

  // Next state: the first payload byte leaves first, most significant bits first.
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    valid_nxt = valid_r;
    last_nxt  = last_r;
    case (state_r)
      shf_pkg::ST_IDLE: begin
        if (start) begin
          state_nxt = shf_pkg::ST_MOVE;
          shift_nxt = word;
          cnt_nxt   = '0;
          valid_nxt = 1'b1;
          last_nxt  = 1'b0;
        end
      end
      shf_pkg::ST_MOVE: begin
        if (out_ready) begin
          if (cnt_r == LAST_IDX) begin
            state_nxt = shf_pkg::ST_IDLE;
            valid_nxt = 1'b0;
            last_nxt  = 1'b0;
          end else begin
            shift_nxt = {shift_r[NBYTES*8-9:0], 8'h00};
            cnt_nxt   = cnt_r + 1'b1;
            last_nxt  = (cnt_r + 1'b1) == LAST_IDX;
          end
        end
      end
      default: begin
        state_nxt = shf_pkg::ST_IDLE;
        valid_nxt = 1'b0;
        last_nxt  = 1'b0;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= shf_pkg::ST_IDLE;
      shift_r <= '0;
      cnt_r   <= '0;
      valid_r <= 1'b0;
      last_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      valid_r <= valid_nxt;
      last_r  <= last_nxt;
    end
  end

  assign idle      = (state_r == shf_pkg::ST_IDLE);
  assign out_valid = valid_r;
  assign out_data  = shift_r[NBYTES*8-1 -: 8];
  assign out_last  = last_r;

endmodule

/* design/shf_rx.sv */
`timescale 1ns/1ps

// Gathers an insertion of NBYTES bytes and pulses done with the whole word.
module shf_rx #(
  parameter int NBYTES = shf_pkg::INS_BYTES
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                in_valid,
  input  wire logic [7:0]          in_data,
  input  wire logic                in_sof,
  output logic                     done,
  output logic [NBYTES*8-1:0]      word
);

  initial begin
    if (NBYTES < 2 || NBYTES > 15) begin
      $error("shf_rx: NBYTES out of range");
    end
  end

  shf_pkg::shf_state_e           state_r, state_nxt;
  logic [NBYTES*8-1:0]           shift_r, shift_nxt;
  logic [shf_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
  logic                          done_r, done_nxt;

  localparam logic [shf_pkg::CNT_W-1:0] LAST_IDX = shf_pkg::CNT_W'(NBYTES - 1);

  // Next state: a start-of-insertion byte always restarts collection.
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    case (state_r)
      shf_pkg::ST_IDLE: begin
        if (in_valid && in_sof) begin
          state_nxt = shf_pkg::ST_MOVE;
          shift_nxt = {shift_r[NBYTES*8-9:0], in_data};
          cnt_nxt   = shf_pkg::CNT_W'(1);
        end
      end
      shf_pkg::ST_MOVE: begin
        if (in_valid) begin
          shift_nxt = {shift_r[NBYTES*8-9:0], in_data};
          if (in_sof) begin
            cnt_nxt = shf_pkg::CNT_W'(1);
          end else if (cnt_r == LAST_IDX) begin
            state_nxt = shf_pkg::ST_IDLE;
            done_nxt  = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      default: begin
        state_nxt = shf_pkg::ST_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= shf_pkg::ST_IDLE;
      shift_r <= '0;
      cnt_r   <= '0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  assign done = done_r;
  assign word = shift_r;

endmodule

/* design/shf_top.sv */
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps

module shf_top #(
  parameter logic [15:0] ETHERTYPE = 16'h9abc  // Arbitrary value.
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  input  wire logic                 tx_start,
  input  wire shf_pkg::shf_fields_s tx_fields,
  output logic                      tx_idle,
  output logic                      tx_out_valid,
  output logic [7:0]                tx_out_data,
  output logic                      tx_out_last,
  input  wire logic                 tx_out_ready,
  input  wire logic                 rx_in_valid,
  input  wire logic [7:0]           rx_in_data,
  input  wire logic                 rx_in_sof,
  output logic                      rx_hdr_valid,
  output shf_pkg::shf_fields_s      rx_fields,
  output logic                      rx_marker_ok,
  output logic                      rx_etype_ok,
  output logic                      rx_rewrite_valid,
  output logic                      rx_learn_enable,
  output logic                      rx_super_priority
);

  // ********************************************************************
  // Header packing and unpacking
  // ********************************************************************

  // Builds the 80-bit header from the fields for the chosen layout.
  function automatic logic [shf_pkg::HDR_BITS-1:0] pack_hdr(
    input shf_pkg::shf_fields_s f,
    input logic                 layout_en
  );
    logic [shf_pkg::HDR_BITS-1:0] h;
    h = '0;
    h[shf_pkg::MARKER_POS] = 1'b1;
    if (layout_en) begin
      h[shf_pkg::COS_HI:shf_pkg::COS_LO]   = f.class_of_service_id;
      h[shf_pkg::INGRESS_SERVICE_INDEX_HI:shf_pkg::INGRESS_SERVICE_INDEX_LO] = f.ingress_service_index;
    end else begin
      h[shf_pkg::AC_HI:shf_pkg::AC_LO]     = f.aggregation_code;
    end
    h[shf_pkg::DP_HI:shf_pkg::DP_LO]     = f.drop_precedence;
    h[shf_pkg::SP_POS]                   = f.super_priority_flag;
    h[shf_pkg::PRIO_HI:shf_pkg::PRIO_LO] = f.internal_priority;
    h[shf_pkg::CONG_POS]                 = f.ingress_congestion_policy;
    h[shf_pkg::TTL_HI:shf_pkg::TTL_LO]   = f.ttl;
    h[shf_pkg::LRN_POS]                  = f.learning_skip;
    h[shf_pkg::FWD_HI:shf_pkg::FWD_LO]   = f.forward_mode;
    h[shf_pkg::DST_HI:shf_pkg::DST_LO]   = f.dst_field;
    h[shf_pkg::LOW_HI:0]                 = f.lower_bits;
    return h;
  endfunction

  // Splits an 80-bit header into fields; unused layout fields read zero.
  function automatic shf_pkg::shf_fields_s unpack_hdr(
    input logic [shf_pkg::HDR_BITS-1:0] h,
    input logic                         layout_en
  );
    shf_pkg::shf_fields_s f;
    f = '0;
    if (layout_en) begin
      f.class_of_service_id   = h[shf_pkg::COS_HI:shf_pkg::COS_LO];
      f.ingress_service_index = h[shf_pkg::INGRESS_SERVICE_INDEX_HI:shf_pkg::INGRESS_SERVICE_INDEX_LO];
    end else begin
      f.aggregation_code      = h[shf_pkg::AC_HI:shf_pkg::AC_LO];
    end
    f.drop_precedence           = h[shf_pkg::DP_HI:shf_pkg::DP_LO];
    f.super_priority_flag       = h[shf_pkg::SP_POS];
    f.internal_priority         = h[shf_pkg::PRIO_HI:shf_pkg::PRIO_LO];
    f.ingress_congestion_policy = h[shf_pkg::CONG_POS];
    f.ttl                       = h[shf_pkg::TTL_HI:shf_pkg::TTL_LO];
    f.learning_skip             = h[shf_pkg::LRN_POS];
    f.forward_mode = shf_pkg::shf_fwd_e'(h[shf_pkg::FWD_HI:shf_pkg::FWD_LO]);
    f.dst_field                 = h[shf_pkg::DST_HI:shf_pkg::DST_LO];
    f.lower_bits                = h[shf_pkg::LOW_HI:0];
    return f;
  endfunction

  // ********************************************************************
  // Registers and state
  // ********************************************************************
  logic                         layout_en_r, layout_en_nxt;
  logic [31:0]                  rdata_r, rdata_nxt;
  logic [3:0]                   status_r, status_nxt;
  logic [31:0]                  bad_cnt_r, bad_cnt_nxt;
  logic [31:0]                  good_cnt_r, good_cnt_nxt;
  logic                         hv_r, hv_nxt;
  shf_pkg::shf_fields_s         fields_r, fields_nxt;
  logic                         mk_r, mk_nxt;
  logic                         et_r, et_nxt;
  logic                         rw_r, rw_nxt;
  logic                         lrn_r, lrn_nxt;
  logic                         sp_r, sp_nxt;
  logic                         rx_done;
  logic [shf_pkg::INS_BITS-1:0] rx_word;
  logic [shf_pkg::HDR_BITS-1:0] rx_hdr;
  logic                         rx_rsv_fault;
  logic                         tx_busy;

  // ********************************************************************
  // Insertion and extraction paths
  // ********************************************************************

  // Sends the tag type and then the packed header.
  shf_tx #(
    .NBYTES (shf_pkg::INS_BYTES)
  ) u_tx (
    .clk       (clk),
    .nrst      (nrst),
    .start     (tx_start),
    .word      ({ETHERTYPE, pack_hdr(tx_fields, layout_en_r)}),
    .idle      (tx_idle),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_last  (tx_out_last),
    .out_ready (tx_out_ready)
  );

  // Collects the twelve inserted bytes of an extracted frame.
  shf_rx #(
    .NBYTES (shf_pkg::INS_BYTES)
  ) u_rx (
    .clk      (clk),
    .nrst     (nrst),
    .in_valid (rx_in_valid),
    .in_data  (rx_in_data),
    .in_sof   (rx_in_sof),
    .done     (rx_done),
    .word     (rx_word)
  );

  assign rx_hdr  = rx_word[shf_pkg::HDR_BITS-1:0];
  assign tx_busy = !tx_idle;

  // Reserved bits that a builder should have left clear.
  assign rx_rsv_fault = (|rx_hdr[shf_pkg::RSVB_HI:shf_pkg::RSVB_LO]) |
                        rx_hdr[shf_pkg::RSVC_POS] | rx_hdr[shf_pkg::RSVD_POS] |
                        rx_hdr[shf_pkg::RSVE_POS];

  // Parsed results, check flags and register file next values.
  always_comb begin
    hv_nxt        = rx_done;
    fields_nxt    = fields_r;
    mk_nxt        = mk_r;
    et_nxt        = et_r;
    rw_nxt        = rw_r;
    lrn_nxt       = lrn_r;
    sp_nxt        = sp_r;
    status_nxt    = status_r;
    bad_cnt_nxt   = bad_cnt_r;
    good_cnt_nxt  = good_cnt_r;
    layout_en_nxt = layout_en_r;
    rdata_nxt     = 32'h0000_0000;
    if (rx_done) begin
      fields_nxt = unpack_hdr(rx_hdr, layout_en_r);
      mk_nxt     = rx_hdr[shf_pkg::MARKER_POS];
      et_nxt     = rx_word[shf_pkg::INS_BITS-1 -: 16] == ETHERTYPE;
      rw_nxt     = (rx_hdr[shf_pkg::FWD_HI:shf_pkg::FWD_LO] == shf_pkg::FWD_LOCAL_LOOKUP) ||
                   (rx_hdr[shf_pkg::FWD_HI:shf_pkg::FWD_LO] == shf_pkg::FWD_GLOBAL_MIRROR);
      lrn_nxt    = !rx_hdr[shf_pkg::LRN_POS];
      sp_nxt     = rx_hdr[shf_pkg::SP_POS];
      status_nxt[shf_pkg::ST_MARKER_BIT] = rx_hdr[shf_pkg::MARKER_POS];
      status_nxt[shf_pkg::ST_ETYPE_BIT]  = rx_word[shf_pkg::INS_BITS-1 -: 16] == ETHERTYPE;
      status_nxt[shf_pkg::ST_RSV_BIT]    = rx_rsv_fault;
      status_nxt[shf_pkg::ST_FWDRSV_BIT] =
        rx_hdr[shf_pkg::FWD_HI:shf_pkg::FWD_LO] == shf_pkg::FWD_RESERVED;
      if (!rx_hdr[shf_pkg::MARKER_POS] ||
          (rx_word[shf_pkg::INS_BITS-1 -: 16] != ETHERTYPE)) begin
        bad_cnt_nxt = bad_cnt_r + 32'h0000_0001;
      end else begin
        good_cnt_nxt = good_cnt_r + 32'h0000_0001;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        shf_pkg::REG_CTRL:       layout_en_nxt = reg_wdata[shf_pkg::CTRL_LAYOUT_BIT];
        shf_pkg::REG_BAD_COUNT:  bad_cnt_nxt   = 32'h0000_0000;
        shf_pkg::REG_GOOD_COUNT: good_cnt_nxt  = 32'h0000_0000;
        default:                 layout_en_nxt = layout_en_r;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        shf_pkg::REG_CTRL:       rdata_nxt = {31'h0, layout_en_r};
        shf_pkg::REG_STATUS:     rdata_nxt = {27'h0, tx_busy, status_r};
        shf_pkg::REG_BAD_COUNT:  rdata_nxt = bad_cnt_r;
        shf_pkg::REG_GOOD_COUNT: rdata_nxt = good_cnt_r;
        default:                 rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      layout_en_r <= shf_pkg::CTRL_LAYOUT_RST;
      rdata_r     <= 32'h0000_0000;
      status_r    <= 4'h0;
      bad_cnt_r   <= 32'h0000_0000;
      good_cnt_r  <= 32'h0000_0000;
      hv_r        <= 1'b0;
      fields_r    <= '0;
      mk_r        <= 1'b0;
      et_r        <= 1'b0;
      rw_r        <= 1'b0;
      lrn_r       <= 1'b0;
      sp_r        <= 1'b0;
    end else begin
      layout_en_r <= layout_en_nxt;
      rdata_r     <= rdata_nxt;
      status_r    <= status_nxt;
      bad_cnt_r   <= bad_cnt_nxt;
      good_cnt_r  <= good_cnt_nxt;
      hv_r        <= hv_nxt;
      fields_r    <= fields_nxt;
      mk_r        <= mk_nxt;
      et_r        <= et_nxt;
      rw_r        <= rw_nxt;
      lrn_r       <= lrn_nxt;
      sp_r        <= sp_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign rx_hdr_valid      = hv_r;
  assign rx_fields         = fields_r;
  assign rx_marker_ok      = mk_r;
  assign rx_etype_ok       = et_r;
  assign rx_rewrite_valid  = rw_r;
  assign rx_learn_enable   = lrn_r;
  assign rx_super_priority = sp_r;

endmodule

/* verif/shf_partner.sv */
`timescale 1ns/1ps

// Far side: takes the built bytes, stalling on request, and feeds them back to the parser.
module shf_partner (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       stall,
  input  wire logic       tx_out_valid,
  input  wire logic [7:0] tx_out_data,
  input  wire logic       tx_out_last,
  output logic            tx_out_ready,
  output logic            rx_in_valid,
  output logic [7:0]      rx_in_data,
  output logic            rx_in_sof
);
  logic first;

  // Ready drops every other cycle while stalling; an idle data line inverts its value every cycle.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_out_ready <= 1'b0;
      rx_in_valid  <= 1'b0;
      rx_in_sof    <= 1'b0;
      rx_in_data   <= 8'h00;
      first        <= 1'b1;
    end else begin
      tx_out_ready <= stall ? !tx_out_ready : 1'b1;
      if (tx_out_valid && tx_out_ready) begin
        rx_in_valid <= 1'b1;
        rx_in_data  <= tx_out_data;
        rx_in_sof   <= first;
        first       <= tx_out_last;
      end else begin
        rx_in_valid <= 1'b0;
        rx_in_sof   <= 1'b0;
        rx_in_data  <= ~rx_in_data;
      end
    end
  end
endmodule

/* verif/shf_checker.sv */
`timescale 1ns/1ps

module shf_checker #(
  parameter logic [15:0] ETHERTYPE = 16'h0000  // Arbitrary value.
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 tx_start,
  input wire logic                 tx_idle,
  input wire logic                 tx_out_valid,
  input wire logic [7:0]           tx_out_data,
  input wire logic                 tx_out_last,
  input wire logic                 tx_out_ready,
  input wire logic                 rx_in_valid,
  input wire logic                 rx_in_sof,
  input wire logic                 rx_hdr_valid,
  input wire shf_pkg::shf_fields_s rx_fields,
  input wire logic                 rx_rewrite_valid,
  input wire logic                 rx_learn_enable,
  input wire logic                 rx_super_priority
);
  logic [3:0] tidx;
  logic [3:0] rcnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Counts bytes accepted on the build side and bytes taken on the parse side.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tidx <= 4'h0;
      rcnt <= 4'h0;
    end else begin
      if (tx_out_valid && tx_out_ready) tidx <= tx_out_last ? 4'h0 : tidx + 4'h1;
      if (rx_in_valid) rcnt <= rx_in_sof ? 4'h1 : (rcnt == 4'hb || rcnt == 4'h0) ? 4'h0 : rcnt + 4'h1;
    end
  end

  // ****
  // Properties
  // ****
  chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  chk_tx_answer: assert property (tx_start && tx_idle |=> tx_out_valid && !tx_idle && tx_out_data == ETHERTYPE[15:8])
    else $error("first tag-type byte missing");
  chk_tx_hold: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data) && $stable(tx_out_last))
    else $error("byte changed while stalled");
  chk_marker_one: assert property (tx_out_valid && tidx == 4'h2 |-> tx_out_data[7])
    else $error("marker bit not one");
  chk_rsv_zero: assert property (tx_out_valid && tidx inside {4'h4, 4'h5, 4'h6} |-> (tidx == 4'h4 ? tx_out_data[7:6] == 2'b00 : tidx == 4'h5 ? tx_out_data[6:5] == 2'b00 : !tx_out_data[3]))
    else $error("reserved bit not zero");
  chk_last_twelve: assert property (tx_out_valid |-> tx_out_last == (tidx == 4'hb))
    else $error("last flag not on byte twelve");
  chk_idle_after: assert property (tx_out_valid && tx_out_ready && tx_out_last |=> tx_idle && !tx_out_valid)
    else $error("builder not idle after last byte");
  chk_rx_answer: assert property (rx_in_valid && !rx_in_sof && rcnt == 4'hb |-> ##2 rx_hdr_valid)
    else $error("header pulse late");
  chk_hdr_pulse: assert property (rx_hdr_valid |=> !rx_hdr_valid)
    else $error("header pulse longer than one cycle");
  chk_learn_skip: assert property (rx_hdr_valid |-> rx_learn_enable == !rx_fields.learning_skip)
    else $error("learn enable wrong");
  chk_super_flag: assert property (rx_hdr_valid |-> rx_super_priority == rx_fields.super_priority_flag)
    else $error("super priority wrong");
  chk_rewrite_mode: assert property (rx_hdr_valid |-> rx_rewrite_valid == (rx_fields.forward_mode inside {shf_pkg::FWD_LOCAL_LOOKUP, shf_pkg::FWD_GLOBAL_MIRROR}))
    else $error("rewrite valid wrong");
  cover property (tx_out_valid && !tx_out_ready);
  cover property (tx_start && !tx_idle);
  cover property (rx_hdr_valid && rx_rewrite_valid);
  cover property (rx_hdr_valid && rx_fields.forward_mode == shf_pkg::FWD_RESERVED);
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  localparam logic [15:0] ETH = 16'h5a3c;  // Arbitrary value.
  typedef struct packed {
    shf_pkg::shf_fields_s f;
    logic                 lay;
    logic [31:0]          st;
  } shf_row_s;
  logic                 clk, nrst, reg_wr, reg_rd, tx_start, tx_idle, tx_out_valid, tx_out_last;
  logic                 tx_out_ready, rx_in_valid, rx_in_sof, rx_hdr_valid, rx_marker_ok;
  logic                 rx_etype_ok, rx_rewrite_valid, rx_learn_enable, rx_super_priority, stall;
  logic [7:0]           reg_addr, tx_out_data, rx_in_data;
  logic [31:0]          reg_wdata, reg_rdata;
  shf_pkg::shf_fields_s tx_fields, rx_fields;
  logic [7:0]           q[$];
  shf_row_s             rows[8];
  int                   fail_count, checks;

  shf_top #(.ETHERTYPE(ETH)) uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_start, .tx_fields, .tx_idle, .tx_out_valid, .tx_out_data, .tx_out_last, .tx_out_ready,
    .rx_in_valid, .rx_in_data, .rx_in_sof, .rx_hdr_valid, .rx_fields, .rx_marker_ok, .rx_etype_ok,
    .rx_rewrite_valid, .rx_learn_enable, .rx_super_priority);
  shf_partner u_far (.clk, .nrst, .stall, .tx_out_valid, .tx_out_data, .tx_out_last,
    .tx_out_ready, .rx_in_valid, .rx_in_data, .rx_in_sof);

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(96'(reg_rdata), 96'(exp));
  endtask
  function automatic logic [79:0] hdr_of(input shf_pkg::shf_fields_s f, input logic lay);
    logic [79:0] h;
    h = '0;
    h[79] = 1'b1;
    if (lay) h[78:64] = {f.class_of_service_id, f.ingress_service_index};
    else h[67:64] = f.aggregation_code;
    h[61:55] = {f.drop_precedence, f.super_priority_flag, f.internal_priority,
      f.ingress_congestion_policy};
    h[52:44] = {f.ttl, f.learning_skip, f.forward_mode};
    h[42:0] = {f.dst_field, f.lower_bits};
    return h;
  endfunction
  task automatic run_row(input shf_row_s r);
    logic [95:0]          got;
    shf_pkg::shf_fields_s e;
    int                   n;
    wr(shf_pkg::REG_CTRL, {31'h0, r.lay});
    q.delete();
    @(posedge clk);
    tx_start  <= 1'b1;
    tx_fields <= r.f;
    @(posedge clk);
    tx_fields <= shf_pkg::shf_fields_s'(~r.f);
    @(posedge clk);
    tx_start <= 1'b0;
    n = 0;
    while (rx_hdr_valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    got = '0;
    foreach (q[k]) got = {got[87:0], q[k]};
    chk(got, {ETH, hdr_of(r.f, r.lay)});
    chk(96'(q.size()), 96'd12);
    e = r.f;
    if (r.lay) e.aggregation_code = '0;
    else {e.class_of_service_id, e.ingress_service_index} = '0;
    chk(96'(rx_fields), 96'(e));
    rc(shf_pkg::REG_STATUS, r.st);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Clock and watchdog.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence: reset values, the table of headers, then counters and a second reset.
  initial begin
    {nrst, reg_wr, reg_rd, tx_start, stall, reg_addr, reg_wdata} = '0;
    tx_fields = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(96'(tx_idle), 96'd1);
    foreach (rows[i]) begin
      rows[i].f = {3'(i), 12'hf00 | 12'(i), 4'(4'h9 ^ i), 2'(i), i[0], 3'(~i), i[1],
        5'(31 - i), i[2], shf_pkg::shf_fwd_e'(i), 11'(11'h7ff ^ i), 32'hdead0000 | i};
      rows[i].lay = i[0];
      rows[i].st = (i == 7) ? 32'hb : 32'h3;
      rc(8'(4 * i), 32'h0);
    end
    foreach (rows[i]) begin
      stall <= i[1];
      run_row(rows[i]);
    end
    rc(shf_pkg::REG_GOOD_COUNT, 32'h8);
    rc(shf_pkg::REG_BAD_COUNT, 32'h0);
    wr(shf_pkg::REG_GOOD_COUNT, 32'h0);
    rc(shf_pkg::REG_GOOD_COUNT, 32'h0);
    wr(8'h10, 32'hffffffff);
    rc(shf_pkg::REG_CTRL, 32'h1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rc(shf_pkg::REG_CTRL, 32'h0);
    tally_and_finish();
  end

  // Records every byte that the far side accepts.
  always @(posedge clk) begin
    if (tx_out_valid && tx_out_ready) q.push_back(tx_out_data);
  end
endmodule

bind shf_top shf_checker #(.ETHERTYPE(ETHERTYPE)) u_chk (.clk, .nrst, .reg_rd, .reg_rdata,
  .tx_start, .tx_idle, .tx_out_valid, .tx_out_data, .tx_out_last, .tx_out_ready, .rx_in_valid,
  .rx_in_sof, .rx_hdr_valid, .rx_fields, .rx_rewrite_valid, .rx_learn_enable, .rx_super_priority);
